// ==== hw/cfs_pkg.sv ====
// shared constants and types for the converter fault supervisor
package cfs_pkg;

  // clock and timing
  localparam int unsigned CLK_FREQ_HZ   = 40_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;
  localparam logic [1:0]  OC_TRIP_COUNT = 2'h3;
  localparam logic [2:0]  HICCUP_IVLS   = 3'h7;

  // bus geometry
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 4;
  localparam int unsigned TW = 12;
  localparam int unsigned NF = 10;

  // register word offsets
  localparam logic [AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [AW-1:0] REG_OVF    = 4'h1;
  localparam logic [AW-1:0] REG_UVF    = 4'h2;
  localparam logic [AW-1:0] REG_OVW    = 4'h3;
  localparam logic [AW-1:0] REG_UVW    = 4'h4;
  localparam logic [AW-1:0] REG_RESP   = 4'h5;
  localparam logic [AW-1:0] REG_TIMING = 4'h6;
  localparam logic [AW-1:0] REG_STATUS = 4'h7;
  localparam logic [AW-1:0] REG_MASK   = 4'h8;
  localparam logic [AW-1:0] REG_STATE  = 4'h9;

  // field positions
  localparam int unsigned CTRL_SCALE_LSB = 0;
  localparam int unsigned CTRL_HOLD_BIT  = 2;
  localparam int unsigned RESP_OV_LSB    = 0;
  localparam int unsigned RESP_UV_LSB    = 2;
  localparam int unsigned RESP_TON_LSB   = 4;
  localparam int unsigned RESP_OC_LSB    = 6;
  localparam int unsigned RESP_OT_LSB    = 8;
  localparam int unsigned TIM_SS_LSB     = 0;
  localparam int unsigned TIM_TON_LSB    = 8;

  // status bit positions
  localparam int unsigned ST_OVF = 0;
  localparam int unsigned ST_UVF = 1;
  localparam int unsigned ST_TON = 2;
  localparam int unsigned ST_OCF = 3;
  localparam int unsigned ST_OTF = 4;
  localparam int unsigned ST_DIE = 5;
  localparam int unsigned ST_OVW = 6;
  localparam int unsigned ST_UVW = 7;
  localparam int unsigned ST_OCW = 8;
  localparam int unsigned ST_OTW = 9;

  // reset values
  localparam logic [2:0]    RST_CTRL   = 3'h0;
  localparam logic [TW-1:0] RST_OVF    = 12'hc00;
  localparam logic [TW-1:0] RST_UVF    = 12'h600;
  localparam logic [TW-1:0] RST_OVW    = 12'hb00;
  localparam logic [TW-1:0] RST_UVW    = 12'h700;
  localparam logic [9:0]    RST_RESP   = 10'h155;
  localparam logic [15:0]   RST_TIMING = 16'h0a03;
  localparam logic [NF-1:0] RST_MASK   = 10'h000;
  localparam logic [TW-1:0] PG_HYST    = 12'h008;

  typedef enum logic [1:0] {
    CFS_LATCH   = 2'h0,
    CFS_RESTART = 2'h1,
    CFS_IGNORE  = 2'h2
  } cfs_resp_t;

  // gray along off, start, run, discharge, hiccup
  typedef enum logic [2:0] {
    CFS_OFF    = 3'h0,
    CFS_START  = 3'h1,
    CFS_RUN    = 3'h3,
    CFS_DISCH  = 3'h2,
    CFS_HICCUP = 3'h6,
    CFS_COOL   = 3'h7,
    CFS_SHUT   = 3'h5
  } cfs_state_t;

endpackage

// ==== hw/cfs_sync.sv ====
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module cfs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cfs_sync_t;

  cfs_sync_t s;
  cfs_sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s        = s;
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;
endmodule

// ==== hw/cfs_supervisor.sv ====
// fault supervisor: limits, responses, power good, register slave
//
// Summary of operation
// - overvoltage and undervoltage judged against host-programmed thresholds
// - overvoltage fault stops switching and turns the low-side switch on
// - overvoltage flags status, alerts unless masked, then latches or restarts
// - overvoltage watch runs once the bias regulator is good, before soft-start
// - overvoltage set to ignore keeps modulation and regulation running
// - undervoltage after soft-start turns both off, then waits or hiccups
// - undervoltage fault flags status and alerts unless masked
// - undervoltage set to ignore keeps operating without interruption
// - startup time limit in ms delays undervoltage judging during startup
// - power good released while output stays inside the warning window
// - power good hysteresis doubles at loop scale 1 and quadruples at scale 2 and 3
// - power good pulled low whenever any fault is present, except an ignored external temperature or overcurrent fault
// - temperature fault with restart: both off until cooled, then resume
// - ignored external temperature or overcurrent fault keeps modulation and power good
// - overcurrent trips after 3 cycles; restart waits 7 soft-start intervals
// - temperature and overcurrent warnings alert and pull power good low only
// - junction overtemperature always shuts off and restarts once cooled
// - hold select keeps low side latched on or only down to undervoltage limit
// - undervoltage or startup-time restart waits 7 soft-start intervals
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module cfs_supervisor
  import cfs_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = CYCLES_PER_MS
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic [AW-1:0] avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [DW-1:0] avs_writedata_in,
  output logic      [DW-1:0] avs_readdata_out,
  output logic               avs_waitrequest_out,
  input  wire logic [TW-1:0] output_sense_pin_in,
  input  wire logic          internal_bias_regulator_ok_in,
  input  wire logic          enable_input_pin_in,
  input  wire logic          ext_temp_fault_in,
  input  wire logic          ext_temp_warn_in,
  input  wire logic          ext_temp_cooled_in,
  input  wire logic          die_overtemp_in,
  input  wire logic          oc_event_in,
  input  wire logic          oc_warn_in,
  input  wire logic          pwm_cycle_in,
  input  wire logic          power_good_pin_in,
  output logic               modulation_enable_out,
  output logic               low_side_force_out,
  output logic               soft_start_out,
  output logic               power_good_out,
  output logic               power_good_oe_out,
  output logic               alert_out
);

  localparam logic [15:0] TICK_LAST = 16'(MS_TICK_CYCLES - 1);

  typedef struct packed {
    cfs_state_t    st;
    logic [15:0]   tick;
    logic [7:0]    ms;
    logic [2:0]    ivl;
    logic [1:0]    occ;
    logic          pwm_prev;
    logic          cool_ext;
    logic          pg_win;
    logic [2:0]    ctrl;
    logic [TW-1:0] ovf;
    logic [TW-1:0] uvf;
    logic [TW-1:0] ovw;
    logic [TW-1:0] uvw;
    logic [9:0]    resp;
    logic [15:0]   timing;
    logic [NF-1:0] status;
    logic [NF-1:0] mask;
    logic          waitrq;
    logic [DW-1:0] rdata;
    logic          mod_en;
    logic          ls_force;
    logic          ss_run;
    logic          pg_pull;
    logic          alert;
  } cfs_sup_t;

  cfs_sup_t s;
  cfs_sup_t next_s;
  logic [9:0] pins;

  // response code of one fault class
  function automatic cfs_resp_t resp_of(input logic [9:0] r,
                                        input int unsigned lsb);
    resp_of = (r[lsb +: 2] == 2'h0) ? CFS_LATCH :
              (r[lsb +: 2] == 2'h1) ? CFS_RESTART : CFS_IGNORE;
  endfunction

  // interval in ms, never shorter than one
  function automatic logic [7:0] at_least_one(input logic [7:0] v);
    at_least_one = (v == 8'h00) ? 8'h01 : v;
  endfunction

  // pins from analog and other clocks
  cfs_sync #(.W(10)) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({power_good_pin_in, pwm_cycle_in, oc_warn_in, oc_event_in,
                die_overtemp_in, ext_temp_cooled_in, ext_temp_warn_in,
                ext_temp_fault_in, enable_input_pin_in,
                internal_bias_regulator_ok_in}),
    .sync_out (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic          bias_ok;
    logic          en;
    logic          pwm_edge;
    logic          ov_now;
    logic          uv_now;
    logic          oc_trip;
    logic          ms_tick;
    logic          ss_done;
    logic          ivl_end;
    logic          acc_wr;
    logic          flt_live;
    logic [7:0]    ss_len;
    logic [7:0]    ton_len;
    logic [TW-1:0] hyst;
    logic [NF-1:0] ev;
    logic [NF-1:0] clr;
    cfs_resp_t     r_ov;
    cfs_resp_t     r_uv;
    cfs_resp_t     r_ton;
    cfs_resp_t     r_oc;
    cfs_resp_t     r_ot;
    next_s   = s;
    bias_ok  = pins[0];
    en       = pins[1];
    pwm_edge = pins[8] && !s.pwm_prev;
    ov_now   = bias_ok && (output_sense_pin_in > s.ovf);
    uv_now   = output_sense_pin_in < s.uvf;
    r_ov     = resp_of(s.resp, RESP_OV_LSB);
    r_uv     = resp_of(s.resp, RESP_UV_LSB);
    r_ton    = resp_of(s.resp, RESP_TON_LSB);
    r_oc     = resp_of(s.resp, RESP_OC_LSB);
    r_ot     = resp_of(s.resp, RESP_OT_LSB);
    ss_len   = at_least_one(s.timing[TIM_SS_LSB +: 8]);
    ton_len  = at_least_one(s.timing[TIM_TON_LSB +: 8]);
    ms_tick  = (s.tick == TICK_LAST);
    ss_done  = (s.ms >= ss_len);
    ivl_end  = ms_tick && (s.ms + 8'h01 >= ss_len);
    ev       = '0;

    // millisecond base and per-state ms counter
    next_s.tick     = ms_tick ? 16'h0000 : s.tick + 16'h0001;
    next_s.pwm_prev = pins[8];
    if (ms_tick && s.ms != 8'hff) begin
      next_s.ms = s.ms + 8'h01;
    end

    // consecutive overcurrent cycles, cleared by a clean cycle
    if (pwm_edge) begin
      if (!pins[6]) begin
        next_s.occ = 2'h0;
      end else if (s.occ != OC_TRIP_COUNT) begin
        next_s.occ = s.occ + 2'h1;
      end
    end
    oc_trip = (s.occ == OC_TRIP_COUNT);

    // default gate drive follows the state
    next_s.mod_en   = 1'b0;
    next_s.ls_force = 1'b0;
    next_s.ss_run   = 1'b0;

    case (s.st)
      CFS_OFF: begin
        if (bias_ok && en) begin
          next_s.st = CFS_START;
          next_s.ms = 8'h00;
        end
      end
      CFS_START: begin
        next_s.mod_en = 1'b1;
        next_s.ss_run = !ss_done;
        // undervoltage judged only once the startup limit runs out
        if (ss_done && !uv_now) begin
          next_s.st = CFS_RUN;
        end else if (ss_done && s.ms >= ton_len && uv_now) begin
          ev[ST_TON] = 1'b1;
          if (r_ton == CFS_LATCH) begin
            next_s.st = CFS_SHUT;
          end else if (r_ton == CFS_RESTART) begin
            next_s.st = CFS_HICCUP;
          end else begin
            next_s.st = CFS_RUN;
          end
          next_s.ms  = 8'h00;
          next_s.ivl = 3'h0;
        end
      end
      CFS_RUN: begin
        next_s.mod_en = 1'b1;
        if (uv_now) begin
          ev[ST_UVF] = 1'b1;
          next_s.ms  = 8'h00;
          next_s.ivl = 3'h0;
          if (r_uv == CFS_LATCH) begin
            next_s.st = CFS_SHUT;
          end else if (r_uv == CFS_RESTART) begin
            next_s.st = CFS_HICCUP;
          end
          // ignore leaves modulation running
        end
      end
      CFS_DISCH: begin
        next_s.ls_force = 1'b1;
        if (!s.ctrl[CTRL_HOLD_BIT] && uv_now) begin
          next_s.ls_force = 1'b0;
          next_s.st  = (r_ov == CFS_RESTART) ? CFS_HICCUP : CFS_SHUT;
          next_s.ms  = 8'h00;
          next_s.ivl = 3'h0;
        end else if (s.ctrl[CTRL_HOLD_BIT] && r_ov == CFS_RESTART) begin
          // low side stays on through the hiccup wait
          if (ivl_end) begin
            next_s.ms  = 8'h00;
            next_s.ivl = s.ivl + 3'h1;
            if (s.ivl + 3'h1 == HICCUP_IVLS) begin
              next_s.st = CFS_START;
            end
          end
        end
      end
      CFS_HICCUP: begin
        // both off for seven soft-start intervals
        if (ivl_end) begin
          next_s.ms  = 8'h00;
          next_s.ivl = s.ivl + 3'h1;
          if (s.ivl + 3'h1 == HICCUP_IVLS) begin
            next_s.st = CFS_START;
          end
        end
      end
      CFS_COOL: begin
        if (s.cool_ext ? pins[4] : !pins[5]) begin
          next_s.st = CFS_START;
          next_s.ms = 8'h00;
        end
      end
      CFS_SHUT: begin
        next_s.st = CFS_SHUT; // only enable low, bias loss, overvoltage, die overtemperature or reset releases it
      end
      default: begin
        next_s.st = CFS_OFF;
      end
    endcase

    // faults that override the state, most severe last; overcurrent acts in start and run, temperature outside off, shut and cool
    if (s.st != CFS_OFF && s.st != CFS_SHUT && s.st != CFS_COOL) begin
      if ((s.st == CFS_START || s.st == CFS_RUN) && oc_trip) begin
        ev[ST_OCF] = 1'b1;
        if (r_oc != CFS_IGNORE) begin
          next_s.st     = (r_oc == CFS_LATCH) ? CFS_SHUT : CFS_HICCUP;
          next_s.mod_en = 1'b0;
          next_s.ms     = 8'h00;
          next_s.ivl    = 3'h0;
          next_s.occ    = 2'h0;
        end
      end
      if (pins[2]) begin
        ev[ST_OTF] = 1'b1;
        if (r_ot != CFS_IGNORE) begin
          next_s.st       = (r_ot == CFS_LATCH) ? CFS_SHUT : CFS_COOL;
          next_s.cool_ext = 1'b1;
          next_s.mod_en   = 1'b0;
          next_s.ls_force = 1'b0;
        end
      end
    end
    if (ov_now) begin
      ev[ST_OVF] = 1'b1;
      if (r_ov != CFS_IGNORE && s.st != CFS_DISCH) begin
        next_s.st       = CFS_DISCH;
        next_s.mod_en   = 1'b0;
        next_s.ls_force = 1'b1;
        next_s.ms       = 8'h00;
        next_s.ivl      = 3'h0;
      end
    end
    if (pins[5] && bias_ok) begin
      ev[ST_DIE]      = 1'b1;
      next_s.st       = CFS_COOL;
      next_s.cool_ext = 1'b0;
      next_s.mod_en   = 1'b0;
      next_s.ls_force = 1'b0;
    end
    if (!bias_ok || !en) begin
      next_s.st       = CFS_OFF;
      next_s.mod_en   = 1'b0;
      next_s.ls_force = 1'b0;
      next_s.ss_run   = 1'b0;
    end
    if (!next_s.mod_en) begin
      next_s.ss_run = 1'b0;
    end

    // warnings flag and pull power good, modulation keeps the switches
    ev[ST_OVW] = (s.st == CFS_RUN) && output_sense_pin_in >= s.ovw;
    ev[ST_UVW] = (s.st == CFS_RUN) && output_sense_pin_in <= s.uvw;
    ev[ST_OCW] = pins[7];
    ev[ST_OTW] = pins[3];

    // power good window, hysteresis widens as loop scale grows
    case (s.ctrl[CTRL_SCALE_LSB +: 2])
      2'h0:    hyst = PG_HYST;
      2'h1:    hyst = PG_HYST << 1;
      default: hyst = PG_HYST << 2;
    endcase
    if (s.pg_win) begin
      next_s.pg_win = !(output_sense_pin_in >= s.ovw ||
                        output_sense_pin_in <= s.uvw);
    end else begin
      next_s.pg_win = (output_sense_pin_in < s.ovw - hyst) &&
                      (output_sense_pin_in > s.uvw + hyst);
    end
    flt_live = ov_now || uv_now || pins[5] || pins[7] || pins[3]
             || (pins[2] && r_ot != CFS_IGNORE)
             || (oc_trip && r_oc != CFS_IGNORE);
    next_s.pg_pull = !(next_s.st == CFS_RUN && s.st == CFS_RUN &&
                       s.pg_win && !flt_live);

    // register slave: one wait cycle, then the access completes
    acc_wr = avs_write_in && !s.waitrq;
    clr    = '0;
    if (acc_wr) begin
      case (avs_address_in)
        REG_CTRL:   next_s.ctrl   = avs_writedata_in[2:0];
        REG_OVF:    next_s.ovf    = avs_writedata_in[TW-1:0];
        REG_UVF:    next_s.uvf    = avs_writedata_in[TW-1:0];
        REG_OVW:    next_s.ovw    = avs_writedata_in[TW-1:0];
        REG_UVW:    next_s.uvw    = avs_writedata_in[TW-1:0];
        REG_RESP:   next_s.resp   = avs_writedata_in[9:0];
        REG_TIMING: next_s.timing = avs_writedata_in[15:0];
        REG_STATUS: clr           = avs_writedata_in[NF-1:0];
        REG_MASK:   next_s.mask   = avs_writedata_in[NF-1:0];
        default:    next_s.mask   = s.mask;
      endcase
    end
    next_s.status = (s.status & ~clr) | ev; // set wins over clear
    next_s.alert  = |(next_s.status & ~s.mask);
    next_s.waitrq = 1'b1;
    if ((avs_read_in || avs_write_in) && s.waitrq) begin
      next_s.waitrq = 1'b0;
      case (avs_address_in)
        REG_CTRL:   next_s.rdata = DW'(s.ctrl);
        REG_OVF:    next_s.rdata = DW'(s.ovf);
        REG_UVF:    next_s.rdata = DW'(s.uvf);
        REG_OVW:    next_s.rdata = DW'(s.ovw);
        REG_UVW:    next_s.rdata = DW'(s.uvw);
        REG_RESP:   next_s.rdata = DW'(s.resp);
        REG_TIMING: next_s.rdata = DW'(s.timing);
        REG_STATUS: next_s.rdata = DW'(s.status);
        REG_MASK:   next_s.rdata = DW'(s.mask);
        REG_STATE:  next_s.rdata = {8'h00, output_sense_pin_in, 3'h0,
                                    pins[9], s.pg_pull, s.alert,
                                    s.ivl, s.st};
        default:    next_s.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s        <= '0;
      s.st     <= CFS_OFF;
      s.ctrl   <= RST_CTRL;
      s.ovf    <= RST_OVF;
      s.uvf    <= RST_UVF;
      s.ovw    <= RST_OVW;
      s.uvw    <= RST_UVW;
      s.resp   <= RST_RESP;
      s.timing <= RST_TIMING;
      s.mask   <= RST_MASK;
      s.waitrq <= 1'b1;
      s.pg_pull <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops; power good is open drain, low when driven
  assign avs_readdata_out      = s.rdata;
  assign avs_waitrequest_out   = s.waitrq;
  assign modulation_enable_out = s.mod_en;
  assign low_side_force_out    = s.ls_force;
  assign soft_start_out        = s.ss_run;
  assign power_good_out        = s.rdata[DW-1] & 1'b0;
  assign power_good_oe_out     = s.pg_pull;
  assign alert_out             = s.alert;
endmodule

// ==== sim/cfs_stage_model.sv ====
// behavioural power stage: switching marker and output sense
`timescale 1ns/1ps
module cfs_stage_model
  import cfs_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          mod_en_in,
  input  wire logic          ls_force_in,
  input  wire logic          pre_in,
  input  wire logic [TW-1:0] target_in,
  output logic      [TW-1:0] sense_out,
  output logic               pwm_out
);
  logic [2:0] ph;

  // switching period of 8 clocks, marker rises once per period
  assign pwm_out = ph[2];

  // discharge wins; pre_in models a pre-biased output with no switching
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ph <= 3'h0;
      sense_out <= '0;
    end else begin
      ph <= ph + 3'h1;
      if (ls_force_in)
        sense_out <= (sense_out > 12'h40) ? sense_out - 12'h40 : '0;
      else if (mod_en_in || pre_in)
        sense_out <= target_in;
      else if (sense_out != '0)
        sense_out <= sense_out - 12'h1; // load bleeds the output slowly
    end
  end
endmodule

// ==== sim/cfs_supervisor_monitor.sv ====
// assertion checker watching the supervisor's ports
`timescale 1ns/1ps
module cfs_sup_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic internal_bias_regulator_ok_in,
  input wire logic die_overtemp_in,
  input wire logic oc_warn_in,
  input wire logic ext_temp_warn_in,
  input wire logic modulation_enable_out,
  input wire logic low_side_force_out,
  input wire logic soft_start_out,
  input wire logic power_good_out,
  input wire logic power_good_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // pins pass two sync stages, so four samples cover the lag
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_bias_lost;
    !internal_bias_regulator_ok_in [*4];
  endsequence
  sequence s_die_hot;
    die_overtemp_in [*4];
  endsequence
  sequence s_warn;
    (oc_warn_in || ext_temp_warn_in) [*4];
  endsequence

  AST_BUS_ACCEPT: assert property (s_req |=> !avs_waitrequest_out)
    else $error("no answer");
  AST_BUS_ONE_LOW: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("wait low twice");
  AST_BUS_NO_SPONT: assert property (!avs_waitrequest_out |->
    $past(avs_read_in || avs_write_in))
    else $error("spurious answer");
  AST_DISCH_NO_PWM: assert property (low_side_force_out |->
    !modulation_enable_out) else $error("pwm in discharge");
  AST_PG_ONLY_RUN: assert property (!power_good_oe_out |->
    modulation_enable_out && !soft_start_out && !low_side_force_out)
    else $error("pg released early");
  AST_PG_OPEN_DRAIN: assert property (!power_good_out)
    else $error("pg drive high");
  AST_SS_PWM: assert property (soft_start_out |->
    modulation_enable_out && !low_side_force_out)
    else $error("soft start idle");
  AST_BIAS_OFF: assert property (s_bias_lost |=>
    !modulation_enable_out && !low_side_force_out)
    else $error("driven unbiased");
  AST_DIE_OFF: assert property (s_die_hot |=>
    !modulation_enable_out && !low_side_force_out && power_good_oe_out)
    else $error("die hot, switches on");
  AST_WARN_PG: assert property (s_warn |=> power_good_oe_out)
    else $error("warn left pg up");
endmodule

bind cfs_supervisor cfs_sup_monitor u_mon (.*);

// ==== sim/cfs_tb.sv ====
// self-checking bench for the converter fault supervisor
`timescale 1ns/1ps
`define CHK(g, x) begin \
  n_tests++; \
  if ((g) !== (x)) begin \
    fail_count++; \
    $display("[FAIL] %0t got %h want %h", $time, g, x); \
  end \
end
module tb
  import cfs_pkg::*;
;
  logic          clk_in, rst_in, avs_read_in, avs_write_in, pre;
  logic [AW-1:0] avs_address_in;
  logic [DW-1:0] avs_writedata_in, avs_readdata_out;
  logic          avs_waitrequest_out, internal_bias_regulator_ok_in;
  logic          enable_input_pin_in, ext_temp_fault_in, ext_temp_warn_in;
  logic          ext_temp_cooled_in, die_overtemp_in, oc_event_in;
  logic          oc_warn_in, pwm_cycle_in, power_good_pin_in, alert_out;
  logic          modulation_enable_out, low_side_force_out, soft_start_out;
  logic          power_good_out, power_good_oe_out;
  logic [TW-1:0] output_sense_pin_in, tgt;
  logic [63:0]   q [$];
  logic [63:0]   e;
  logic [31:0]   seed = 32'h7735;
  int            fail_count = 0;
  int            n_tests = 0;
  int            cyc = 0;
  logic [DW-1:0] rv [9] = '{32'(RST_CTRL), 32'(RST_OVF), 32'(RST_UVF),
    32'(RST_OVW), 32'(RST_UVW), 32'(RST_RESP), 32'(RST_TIMING), '0,
    32'(RST_MASK)};

  // pull-up on the open-drain power good line
  assign power_good_pin_in = !power_good_oe_out;

  cfs_supervisor #(.MS_TICK_CYCLES(4)) u_dut (.*);

  cfs_stage_model u_stage (.clk_in, .rst_in,
    .mod_en_in(modulation_enable_out), .ls_force_in(low_side_force_out),
    .pre_in(pre), .target_in(tgt), .sense_out(output_sense_pin_in),
    .pwm_out(pwm_cycle_in));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one access; a read queues its expected value and mask
  task automatic bus(input logic wr, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, input logic [DW-1:0] m);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    if (!wr)
      q.push_back({d, m});
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic st(input logic [2:0] s, input logic p);
    bus(1'b0, REG_STATE, {24'h0, p, 4'h0, s}, 32'h87);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // read data is taken only at the edge that sees waitrequest low
  always @(posedge clk_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0) begin
      e = q.pop_front();
      `CHK(avs_readdata_out & e[31:0], e[63:32])
    end
  end

  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    rst_in = 1'b1;
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
    {internal_bias_regulator_ok_in, enable_input_pin_in, ext_temp_fault_in,
     ext_temp_warn_in, ext_temp_cooled_in, die_overtemp_in, oc_event_in,
     oc_warn_in, pre} = '0;
    tgt = '0;
    w(5);
    rst_in <= 1'b0;
    w(1);
    // reset values, an unmapped slot and the read-only state word
    foreach (rv[i]) bus(1'b0, AW'(i), rv[i], '1);
    bus(1'b0, 4'ha, '0, '1);
    bus(1'b1, 4'ha, '1, '0);
    bus(1'b1, REG_STATE, '1, '0);
    st(CFS_OFF, 1'b1);
    // power up with a random level inside the good window
    tgt <= 12'h780 + 12'(rnd() & 32'h1ff);
    internal_bias_regulator_ok_in <= 1'b1;
    enable_input_pin_in <= 1'b1;
    w(60);
    st(CFS_RUN, 1'b0);
    // overvoltage with restart: discharge, flag, alert, long hiccup
    tgt <= 12'hd00;
    w(4);
    st(CFS_DISCH, 1'b1);
    tgt <= 12'h900;
    bus(1'b0, REG_STATUS, 32'h1, 32'h1);
    bus(1'b0, REG_STATE, 32'h40, 32'h40);
    w(80);
    st(CFS_HICCUP, 1'b1);
    w(50);
    st(CFS_RUN, 1'b0);
    // overvoltage set to ignore keeps switching
    bus(1'b1, REG_RESP, 32'h156, '0);
    tgt <= 12'hd00;
    w(10);
    st(CFS_RUN, 1'b1);
    tgt <= 12'h900;
    bus(1'b1, REG_RESP, 32'h151, '0);
    w(10);
    // undervoltage latch, then the alert masked away
    tgt <= 12'h300;
    w(6);
    st(CFS_SHUT, 1'b1);
    bus(1'b0, REG_STATUS, 32'h2, 32'h2);
    bus(1'b1, REG_MASK, 32'h3ff, '0);
    w(3);
    bus(1'b0, REG_STATE, 32'h0, 32'h40);
    bus(1'b1, REG_MASK, 32'h0, '0);
    enable_input_pin_in <= 1'b0;
    tgt <= 12'h900;
    w(6);
    enable_input_pin_in <= 1'b1;
    w(60);
    st(CFS_RUN, 1'b0);
    // undervoltage set to ignore
    bus(1'b1, REG_RESP, 32'h159, '0);
    tgt <= 12'h300;
    w(10);
    st(CFS_RUN, 1'b1);
    bus(1'b1, REG_RESP, 32'h155, '0);
    // startup never reaching the limit: waits past soft start, then trips
    enable_input_pin_in <= 1'b0;
    w(6);
    enable_input_pin_in <= 1'b1;
    w(20);
    st(CFS_START, 1'b1);
    w(30);
    st(CFS_HICCUP, 1'b1);
    bus(1'b0, REG_STATUS, 32'h4, 32'h4);
    tgt <= 12'h900;
    w(120);
    // overcurrent needs three flagged switching cycles in a row
    @(posedge pwm_cycle_in);
    w(4);
    oc_event_in <= 1'b1;
    repeat (2) @(posedge pwm_cycle_in);
    w(4);
    bus(1'b0, REG_STATE, 32'(CFS_RUN), 32'h7);
    @(posedge pwm_cycle_in);
    w(5);
    st(CFS_HICCUP, 1'b1);
    oc_event_in <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h8, 32'h8);
    w(120);
    bus(1'b1, REG_RESP, 32'h195, '0);
    oc_event_in <= 1'b1;
    w(40);
    st(CFS_RUN, 1'b0);
    oc_event_in <= 1'b0;
    bus(1'b1, REG_RESP, 32'h155, '0);
    // external temperature restart waits for the cooled signal
    ext_temp_fault_in <= 1'b1;
    w(6);
    st(CFS_COOL, 1'b1);
    ext_temp_fault_in <= 1'b0;
    w(10);
    st(CFS_COOL, 1'b1);
    ext_temp_cooled_in <= 1'b1;
    w(60);
    ext_temp_cooled_in <= 1'b0;
    st(CFS_RUN, 1'b0);
    bus(1'b1, REG_RESP, 32'h255, '0);
    ext_temp_fault_in <= 1'b1;
    w(10);
    st(CFS_RUN, 1'b0);
    // die overtemperature ignores the ignore setting
    die_overtemp_in <= 1'b1;
    w(6);
    st(CFS_COOL, 1'b1);
    die_overtemp_in <= 1'b0;
    ext_temp_fault_in <= 1'b0;
    w(60);
    st(CFS_RUN, 1'b0);
    // temperature and overcurrent warnings each keep switching, flag status, pull power good
    for (int k = 0; k < 2; k++) begin
      {oc_warn_in, ext_temp_warn_in} <= 2'(k + 1);
      w(6);
      st(CFS_RUN, 1'b1);
      bus(1'b0, REG_STATUS, 32'h200 >> k, 32'h200 >> k);
      {oc_warn_in, ext_temp_warn_in} <= 2'h0;
      w(6);
    end
    // overvoltage while off and not switching is still caught
    enable_input_pin_in <= 1'b0;
    bus(1'b1, REG_STATUS, '1, '0);
    pre <= 1'b1;
    tgt <= 12'hd00;
    w(8);
    bus(1'b0, REG_STATUS, 32'h1, 32'h1);
    pre <= 1'b0;
    tgt <= 12'h900;
    enable_input_pin_in <= 1'b1;
    w(250);
    st(CFS_RUN, 1'b0);
    // hold select keeps the low side on far below the undervoltage limit
    bus(1'b1, REG_CTRL, 32'h4, '0);
    bus(1'b1, REG_RESP, 32'h154, '0);
    tgt <= 12'hd00;
    w(4);
    tgt <= 12'h900;
    w(80);
    st(CFS_DISCH, 1'b1);
    w(2);
    report_and_stop();
  end
endmodule
